/* File: fpbc_pkg.sv */
// shared constants and carriers for the coprocessor bounce control block
package fpbc_pkg;

   // register byte offsets on the ahb-lite slave
   localparam logic [7:0] OFF_EXC_CTRL = 8'h00;
   localparam logic [7:0] OFF_FAULT = 8'h04;
   localparam logic [7:0] OFF_PRETRIG = 8'h08;
   localparam logic [7:0] OFF_SYS_ID = 8'h0c;

   // exception_control_reg field positions
   localparam int EX_BIT = 31;
   localparam int EN_BIT = 30;
   localparam int V2_BIT = 28;
   localparam int VECTOR_ITERATION_FIELD_LSB = 8;
   localparam int CAUSE_LSB = 0;

   // reset values
   localparam logic [31:0] EXC_CTRL_RST = 32'h4000_0700;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   // arbitrary neutral identification value
   localparam logic [31:0] SYS_ID_VAL = 32'h0000_5a01;

   // control register numbers seen by move_to/move_from_ctrl_reg
   localparam logic [3:0] CR_SYS_ID = 4'h0;
   localparam logic [3:0] CR_STATUS = 4'h1;
   localparam logic [3:0] CR_EXC_CTRL = 4'h8;
   localparam logic [3:0] CR_FAULT = 4'h9;
   localparam logic [3:0] CR_PRETRIG = 4'ha;

   // transfer and bank limits
   localparam logic [5:0] MAX_XFER = 6'h20;
   localparam logic [3:0] BANK_SGL = 4'h8;
   localparam logic [3:0] BANK_DBL = 4'h4;
   // cycles after detection from which a new issue is the trigger
   localparam logic [1:0] TRIG_GAP = 2'h2;

   // instruction presented in the decode stage by the core interface
   typedef struct packed {
      logic valid;
      logic stalled;      // held by register or resource hazard
      logic priv;         // core is in a privileged mode
      logic is_ldst;
      logic is_ldm;
      logic is_ctrl;      // move_to_ctrl_reg or move_from_ctrl_reg
      logic [3:0] ctrl_num;
      logic reserved_op;
      logic pwu_undef;
      logic [5:0] xfer_cnt;
      logic is_vec;
      logic [2:0] vec_len;  // length minus one
      logic stride2;
      logic dbl;
      logic [31:0] word;
   } fpbc_dec_t;

   // potential exception report from the first_execute_stage
   typedef struct packed {
      logic detect;
      logic is_vec;
      logic [3:0] cause;
      logic [2:0] remain;  // iterations left after the offending one
      logic [4:0] fd;
      logic [4:0] fn;
      logic [4:0] fm;
      logic [31:0] word;
   } fpbc_exc_t;

endpackage

/* File: fpbc_bounce.sv */
// bounce and trigger selection for the floating-point coprocessor
//
// What this block does
// - pure illegal bounce leaves exceptional_state_flag clear
// - illegal with pending exception reports flag set
// - bounce reserved opcode combinations
// - bounce undefined load/store P W U combinations
// - bounce control moves to undefined registers
// - bounce user mode moves to privileged registers
// - bounce multiples of zero or over thirty-two
// - bounce vectors that touch a register twice
// - overlapping but unequal vectors are not bounced
// - capture completed next instruction as pre-trigger
// - privileged exception register access is not trigger
// - decode-stalled instruction becomes the trigger
// - issue two cycles after detection is trigger
// - vector window loads and stores pass through
// - scalar detect loads word and records cause
// - block offender, let earlier instructions retire
// - no decode instruction, bounce next one issued
// - occupied decode bounces the cycle after detect
// - directly following control moves still bounce
// - stop later vector iterations, earlier ones retire
// - vector detect rewrites registers and iteration code
// - iteration code is remaining count minus one
// - second_instr_valid_flag marks valid pre-trigger word
// - exception signalled by refusing the next instruction
`timescale 1ns/1ns
module fpbc_bounce (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // decode stage and execute reports
   input wire fpbc_pkg::fpbc_dec_t dec_i,
   input wire fpbc_pkg::fpbc_exc_t exc_i,
   // handshake answers to the core
   output logic bounce_o,
   output logic exec_block_o,
   output logic exc_pending_o,
   // ahb-lite register slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o
);

   // reset release through two flops
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // vector touches a register twice when length times stride overflows
   function automatic logic vec_wraps(input logic [2:0] len_m1,
                                      input logic stride2,
                                      input logic dbl);
      logic [4:0] span;
      span = {1'b0, 4'({1'b0, len_m1} + 4'h1)} << stride2;
      return span > {1'b0, (dbl ? fpbc_pkg::BANK_DBL : fpbc_pkg::BANK_SGL)};
   endfunction

   // put the offending iteration's registers into the word
   function automatic logic [31:0] set_regs(input logic [31:0] w,
                                            input logic [4:0] fd,
                                            input logic [4:0] fn,
                                            input logic [4:0] fm);
      logic [31:0] r;
      r = w;
      r[15:12] = fd[4:1];
      r[22] = fd[0];
      r[19:16] = fn[4:1];
      r[7] = fn[0];
      r[3:0] = fm[4:1];
      r[5] = fm[0];
      return r;
   endfunction

   // state
   logic ex_r;
   logic en_r;
   logic v2_r;
   logic [2:0] vector_iteration_field_r;
   logic [3:0] cause_r;
   logic [31:0] fault_r;
   logic [31:0] pretrig_r;
   logic vec_r;
   logic first_after_r;
   logic [1:0] gap_r;
   logic acc_prev_r;
   logic [31:0] acc_word_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;

   // illegal instruction decode
   wire ctrl_defined = dec_i.ctrl_num inside {fpbc_pkg::CR_SYS_ID,
      fpbc_pkg::CR_STATUS, fpbc_pkg::CR_EXC_CTRL, fpbc_pkg::CR_FAULT,
      fpbc_pkg::CR_PRETRIG};
   wire ctrl_priv_only = dec_i.ctrl_num inside {fpbc_pkg::CR_EXC_CTRL,
      fpbc_pkg::CR_FAULT, fpbc_pkg::CR_PRETRIG};
   wire exc_reg_access = dec_i.is_ctrl && (ctrl_priv_only ||
      dec_i.ctrl_num == fpbc_pkg::CR_SYS_ID);
   wire ill_reserved = dec_i.reserved_op;
   wire ill_pwu = dec_i.is_ldst && dec_i.pwu_undef;
   wire ill_ctrl = dec_i.is_ctrl && !ctrl_defined;
   wire ill_user = dec_i.is_ctrl && !dec_i.priv && ctrl_priv_only;
   wire ill_xfer = dec_i.is_ldm && (dec_i.xfer_cnt == 6'h00 ||
      dec_i.xfer_cnt > fpbc_pkg::MAX_XFER);
   // only wrap is checked; partial overlap runs unchecked
   wire ill_vec = dec_i.is_vec &&
      vec_wraps(dec_i.vec_len, dec_i.stride2, dec_i.dbl);
   wire illegal = ill_reserved || ill_pwu || ill_ctrl || ill_user ||
      ill_xfer || ill_vec;

   // trigger selection while exceptional
   wire exempt = dec_i.priv && exc_reg_access && !first_after_r;
   wire vec_pass = vec_r && dec_i.is_ldst && !dec_i.stalled &&
      gap_r != fpbc_pkg::TRIG_GAP;
   wire trig = ex_r && !exempt && !vec_pass;
   wire disabled = !en_r && !(dec_i.is_ctrl && dec_i.priv);
   wire bounce = dec_i.valid && (illegal || trig || disabled);

   // ahb-lite decode
   wire ahb_go = hsel_i && hready_i && htrans_i[1];
   wire [7:0] a_off = haddr_i[7:0];
   wire wr_ctrl = wr_pend_r && wr_addr_r == fpbc_pkg::OFF_EXC_CTRL;
   wire wr_fault = wr_pend_r && wr_addr_r == fpbc_pkg::OFF_FAULT;
   wire wr_pre = wr_pend_r && wr_addr_r == fpbc_pkg::OFF_PRETRIG;
   wire [31:0] ctrl_word = {ex_r, en_r, 1'b0, v2_r, 16'h0000, 1'b0,
      vector_iteration_field_r, 4'h0, cause_r};
   wire [31:0] rd_word = (a_off == fpbc_pkg::OFF_EXC_CTRL) ? ctrl_word :
      (a_off == fpbc_pkg::OFF_FAULT) ? fault_r :
      (a_off == fpbc_pkg::OFF_PRETRIG) ? pretrig_r :
      (a_off == fpbc_pkg::OFF_SYS_ID) ? fpbc_pkg::SYS_ID_VAL : 32'h0000_0000;

   // outputs
   assign bounce_o = bounce;
   assign exec_block_o = ex_r;
   assign exc_pending_o = ex_r;
   assign hrdata_o = hrdata_r;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // bus pipeline: address phase latched, write done in data phase
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= ahb_go && hwrite_i && hsize_i == 3'h2;
         wr_addr_r <= a_off;
         if (ahb_go && !hwrite_i) begin
            hrdata_r <= rd_word;
         end
      end
   end

   // exceptional_state_flag: detection wins over a software clear
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ex_r <= 1'b0;
         en_r <= fpbc_pkg::EXC_CTRL_RST[fpbc_pkg::EN_BIT];
      end else begin
         if (exc_i.detect) begin
            ex_r <= 1'b1;
         end else if (wr_ctrl) begin
            ex_r <= hwdata_i[fpbc_pkg::EX_BIT];
         end
         if (wr_ctrl) begin
            en_r <= hwdata_i[fpbc_pkg::EN_BIT];
         end
      end
   end
   // an illegal bounce never touches ex_r, so it reads 0 or the pending 1

   // faulting word, cause and iteration code
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         fault_r <= fpbc_pkg::WORD_RST;
         cause_r <= 4'h0;
         vector_iteration_field_r <= 3'h7;
         vec_r <= 1'b0;
      end else if (exc_i.detect) begin
         cause_r <= exc_i.cause;
         vec_r <= exc_i.is_vec;
         fault_r <= exc_i.is_vec ? set_regs(exc_i.word, exc_i.fd, exc_i.fn,
            exc_i.fm) : exc_i.word;
         vector_iteration_field_r <= exc_i.is_vec ? 3'(exc_i.remain - 3'h1) : 3'h7;
      end else begin
         if (wr_fault) begin
            fault_r <= hwdata_i;
         end
         if (wr_ctrl) begin
            cause_r <= hwdata_i[fpbc_pkg::CAUSE_LSB +: 4];
            vector_iteration_field_r <= hwdata_i[fpbc_pkg::VECTOR_ITERATION_FIELD_LSB +: 3];
         end
      end
   end

   // pre-trigger capture of the instruction already completed
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         v2_r <= 1'b0;
         pretrig_r <= fpbc_pkg::WORD_RST;
      end else if (exc_i.detect) begin
         v2_r <= !exc_i.is_vec && acc_prev_r;
         if (!exc_i.is_vec && acc_prev_r) begin
            pretrig_r <= acc_word_r;
         end
      end else begin
         if (wr_ctrl) begin
            v2_r <= hwdata_i[fpbc_pkg::V2_BIT];
         end
         if (wr_pre) begin
            pretrig_r <= hwdata_i;
         end
      end
   end

   // last accepted instruction and trigger timing since detection
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         acc_prev_r <= 1'b0;
         acc_word_r <= fpbc_pkg::WORD_RST;
         first_after_r <= 1'b0;
         gap_r <= 2'h0;
      end else begin
         acc_prev_r <= dec_i.valid && !bounce && !ex_r;
         if (dec_i.valid) begin
            acc_word_r <= dec_i.word;
         end
         if (exc_i.detect) begin
            first_after_r <= 1'b1;
            gap_r <= 2'h1;
         end else begin
            if (dec_i.valid) begin
               first_after_r <= 1'b0;
            end
            if (gap_r != 2'h0 && gap_r != fpbc_pkg::TRIG_GAP) begin
               gap_r <= 2'(gap_r + 2'h1);
            end
         end
      end
   end

   // checks on the design's own outputs
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_r);

   sequence s_detect_scalar;
      exc_i.detect && !exc_i.is_vec;
   endsequence

   sequence s_cdp_in_decode;
      dec_i.valid && !dec_i.is_ldst && !exc_reg_access;
   endsequence

   illegal_keeps_clear_a: assert property (
      !ex_r && !exc_i.detect && !wr_ctrl && dec_i.valid && illegal
      |=> !ex_r)
      else $error("illegal bounce set the exceptional flag");

   illegal_with_pend_a: assert property (
      ex_r && dec_i.valid && illegal |-> bounce_o && ctrl_word[31])
      else $error("illegal instr during pending exception not flagged");

   illegal_bounces_a: assert property (
      dec_i.valid && (ill_reserved || ill_pwu || ill_ctrl || ill_user ||
      ill_xfer || ill_vec) |-> bounce_o)
      else $error("illegal instruction accepted");

   detect_loads_a: assert property (
      s_detect_scalar |=> ex_r && fault_r == $past(exc_i.word) &&
      cause_r == $past(exc_i.cause))
      else $error("scalar detection not recorded");

   next_cycle_bounce_a: assert property (
      s_detect_scalar ##1 s_cdp_in_decode |-> bounce_o)
      else $error("decode instruction not bounced after detection");

   gap_trigger_a: assert property (
      exc_i.detect && !wr_ctrl ##1 !exc_i.detect && !wr_ctrl
      ##1 dec_i.valid && !exempt |-> bounce_o)
      else $error("issue two cycles after detection not bounced");

   stalled_trigger_a: assert property (
      ex_r && dec_i.valid && dec_i.stalled && !exempt |-> bounce_o)
      else $error("stalled decode instruction not made trigger");

   vec_ldst_pass_a: assert property (
      exc_i.detect && exc_i.is_vec && en_r && !wr_ctrl ##1
      dec_i.valid && dec_i.is_ldst && !dec_i.stalled && !illegal
      |-> !bounce_o)
      else $error("load or store bounced in vector window");

   iter_code_a: assert property (
      exc_i.detect && exc_i.is_vec |=>
      vector_iteration_field_r == 3'($past(exc_i.remain) - 3'h1))
      else $error("vector iteration code wrong");

   pretrig_valid_a: assert property (
      (s_detect_scalar and acc_prev_r) |=> v2_r &&
      pretrig_r == $past(acc_word_r))
      else $error("pre-trigger word not captured");

   priv_exempt_a: assert property (
      ex_r && !first_after_r && en_r && dec_i.valid && dec_i.priv &&
      exc_reg_access && !illegal |-> !bounce_o)
      else $error("privileged exception register access bounced");

   block_hold_a: assert property (
      exc_i.detect |=> exec_block_o [*2] or
      (exec_block_o ##1 $past(wr_ctrl)))
      else $error("offending instruction not blocked");

   // refusal and capture details checked one by one
   sequence s_detect_vector;
      exc_i.detect && exc_i.is_vec;
   endsequence

   undef_ctrl_a: assert property (
      dec_i.valid && dec_i.is_ctrl && !ctrl_defined |-> bounce_o)
      else $error("move to undefined control register accepted");

   user_priv_a: assert property (
      dec_i.valid && dec_i.is_ctrl && !dec_i.priv && ctrl_priv_only
      |-> bounce_o)
      else $error("user mode move to privileged register accepted");

   ldm_count_a: assert property (
      dec_i.valid && dec_i.is_ldm && (dec_i.xfer_cnt == 6'h00 ||
      dec_i.xfer_cnt > fpbc_pkg::MAX_XFER) |-> bounce_o)
      else $error("multiple transfer with bad count accepted");

   no_spurious_a: assert property (
      !ex_r && en_r && dec_i.valid && !illegal |-> !bounce_o)
      else $error("legal instruction bounced with nothing pending");

   scalar_trigger_a: assert property (
      ex_r && !vec_r && dec_i.valid && !exc_reg_access |-> bounce_o)
      else $error("instruction after scalar detection not bounced");

   first_move_a: assert property (
      exc_i.detect ##1 dec_i.valid && exc_reg_access && !dec_i.is_ldst
      |-> bounce_o)
      else $error("control move right after detection not bounced");

   vec_regs_a: assert property (
      s_detect_vector |=> ex_r &&
      {fault_r[15:12], fault_r[22]} == $past(exc_i.fd) &&
      {fault_r[19:16], fault_r[7]} == $past(exc_i.fn) &&
      {fault_r[3:0], fault_r[5]} == $past(exc_i.fm))
      else $error("vector iteration registers not written");

   vec_no_v2_a: assert property (
      s_detect_vector |=> !v2_r)
      else $error("second valid flag set on a vector detection");

   clear_write_a: assert property (
      wr_ctrl && !exc_i.detect && !hwdata_i[fpbc_pkg::EX_BIT] |=> !ex_r)
      else $error("software clear of the exceptional flag lost");

endmodule // fpbc_bounce

/* File: fpbc_core_model.sv */
// host core side model: issues, holds and retries coprocessor instructions
`timescale 1ns/1ns
module fpbc_core_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // requests from the bench
   input wire logic issue_i,
   input wire logic retry_i,
   input wire fpbc_pkg::fpbc_dec_t instr_i,
   // coprocessor answer
   input wire logic bounce_i,
   // decode stage seen by the coprocessor
   output fpbc_pkg::fpbc_dec_t dec_o
);
   fpbc_pkg::fpbc_dec_t held_r;

   // refused word kept for its retry; idle fields toggle so stale data shows
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         held_r <= '0;
         dec_o <= '0;
      end else begin
         if (dec_o.valid && bounce_i)
            held_r <= dec_o;
         if (retry_i)
            dec_o <= held_r;
         else if (issue_i)
            dec_o <= instr_i;
         else
            dec_o <= {1'b0, ~dec_o[54:0]}; // valid is the top bit
      end
   end
endmodule // fpbc_core_model

/* File: tb.sv */
// self-checking bench for the coprocessor bounce control block
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic iss = 1'b0;
   logic rty = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] seed = 32'h0000_005a;
   logic [31:0] hrdata, q;
   logic hready, hresp, bounce, blk, pend;
   fpbc_pkg::fpbc_dec_t ins = '0;
   fpbc_pkg::fpbc_dec_t dec;
   fpbc_pkg::fpbc_exc_t exc = '0;
   int n_fail = 0;
   int total_checks = 0;

   fpbc_core_model core (.ref_clk_i(clk), .rst_n_i(rst_n), .issue_i(iss),
      .retry_i(rty), .instr_i(ins), .bounce_i(bounce), .dec_o(dec));
   fpbc_bounce uut (.ref_clk_i(clk), .rst_n_i(rst_n), .dec_i(dec),
      .exc_i(exc), .bounce_o(bounce), .exec_block_o(blk),
      .exc_pending_o(pend), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp));

   always #50 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // class k: 0 data op, 1 load/store, 2 multiple, 3 control move
   function automatic fpbc_pkg::fpbc_dec_t mk(input logic [1:0] k,
         input logic [5:0] v, input logic [4:0] s);
      fpbc_pkg::fpbc_dec_t d;
      d = '0;
      d.valid = 1'b1;
      d.is_ldst = (k == 2'h1);
      d.pwu_undef = (k == 2'h1) & v[0];
      d.is_ldm = (k == 2'h2);
      d.xfer_cnt = v;
      d.is_ctrl = (k == 2'h3);
      d.ctrl_num = v[3:0];
      d.priv = v[4];
      d.is_vec = (k == 2'h0) & s[4];
      d.vec_len = s[2:0];
      d.stride2 = s[3];
      d.dbl = v[0];
      d.word = rnd();
      return d;
   endfunction

   // refusal expected from the decode alone, nothing pending
   function automatic logic ill(input fpbc_pkg::fpbc_dec_t d);
      logic [4:0] span;
      logic def, prv;
      span = ({2'h0, d.vec_len} + 5'h01) << d.stride2;
      prv = (d.ctrl_num inside {4'h8, 4'h9, 4'ha});
      def = prv | (d.ctrl_num inside {4'h0, 4'h1});
      return d.reserved_op | (d.is_ldst & d.pwu_undef)
         | (d.is_ctrl & (!def | (prv & !d.priv)))
         | (d.is_ldm & (d.xfer_cnt == 6'h00 || d.xfer_cnt > 6'h20))
         | (d.is_vec & (span > (d.dbl ? 5'h04 : 5'h08)));
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // single word transfer; hsel stays up, idle shown by htrans
   task automatic bus(input logic [7:0] a, input logic w,
         input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   // one decode cycle through the core model, answer checked mid-cycle
   task automatic op(input fpbc_pkg::fpbc_dec_t d, input logic eb,
         input logic re);
      ins <= d;
      if (re)
         rty <= 1'b1;
      else
         iss <= 1'b1;
      @(posedge clk);
      iss <= 1'b0;
      rty <= 1'b0;
      @(negedge clk);
      chk("bounce", bounce, eb);
      @(posedge clk);
   endtask

   task automatic leg(input logic [1:0] k, input logic [5:0] v,
         input logic [4:0] s);
      fpbc_pkg::fpbc_dec_t d;
      d = mk(k, v, s);
      op(d, ill(d), 1'b0);
   endtask

   task automatic det(input logic v, input logic [2:0] rem,
         output fpbc_pkg::fpbc_exc_t e);
      logic [63:0] r;
      r = {rnd(), rnd()};
      e = r[55:0];
      e.detect = 1'b1;
      e.is_vec = v;
      e.remain = rem;
      exc <= e;
      @(posedge clk);
      exc.detect <= 1'b0;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // hang guard, about forty times the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end

   initial begin
      fpbc_pkg::fpbc_exc_t e;
      fpbc_pkg::fpbc_dec_t a;
      logic [31:0] rv [5];
      logic [2:0] rems [3];
      rv = '{fpbc_pkg::EXC_CTRL_RST, fpbc_pkg::WORD_RST, fpbc_pkg::WORD_RST,
         fpbc_pkg::SYS_ID_VAL, 32'h0};
      rems = '{3'h2, 3'h0, 3'h7};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      bus(8'h10, 1'b1, 32'hffff_ffff);
      for (int i = 0; i < 5; i++) begin
         bus(8'(i * 4), 1'b0, 32'h0);
         chk("register", q, rv[i]);
      end
      chk("hresp", hresp, 1'b0);
      $display("test reset values done");
      // corner decodes, then random ones, with nothing pending
      leg(2'h2, 6'h00, 5'h00);
      leg(2'h2, 6'h20, 5'h00);
      leg(2'h2, 6'h21, 5'h00);
      leg(2'h1, 6'h01, 5'h00);
      leg(2'h1, 6'h00, 5'h00);
      leg(2'h3, 6'h15, 5'h00);
      leg(2'h3, 6'h08, 5'h00);
      leg(2'h3, 6'h18, 5'h00);
      leg(2'h0, 6'h00, 5'h17);
      leg(2'h0, 6'h00, 5'h1f);
      leg(2'h0, 6'h01, 5'h13);
      leg(2'h0, 6'h01, 5'h14);
      repeat (200) begin
         a = mk(2'(rnd()), 6'(rnd()), 5'(rnd()));
         a.reserved_op = &3'(rnd());
         op(a, ill(a), 1'b0);
      end
      bus(fpbc_pkg::OFF_EXC_CTRL, 1'b0, 32'h0);
      chk("flag", q[31], 1'b0);
      $display("test illegal decode done");
      // scalar exception with an instruction in the pre-trigger slot
      a = mk(2'h0, 6'h00, 5'h00);
      op(a, 1'b0, 1'b0);
      fork
         det(1'b0, 3'h0, e);
         op(mk(2'h0, 6'h00, 5'h00), 1'b1, 1'b0);
      join
      chk("pending", pend, 1'b1);
      chk("block", blk, 1'b1);
      bus(fpbc_pkg::OFF_EXC_CTRL, 1'b0, 32'h0);
      chk("ctrl", q & 32'h9000_000f, {4'h9, 24'h0, e.cause});
      bus(fpbc_pkg::OFF_FAULT, 1'b0, 32'h0);
      chk("fault", q, e.word);
      bus(fpbc_pkg::OFF_PRETRIG, 1'b0, 32'h0);
      chk("pretrig", q, a.word);
      bus(fpbc_pkg::OFF_EXC_CTRL, 1'b1, 32'h4000_0000);
      @(negedge clk);
      chk("pending", pend, 1'b0);
      op(a, 1'b0, 1'b1);
      $display("test scalar exception done");
      // vector exceptions: iteration code, privileged moves, pending refusal
      foreach (rems[i]) begin
         a = mk(2'h1, 6'h00, 5'h00);
         fork
            det(1'b1, rems[i], e);
            op(a, 1'b0, 1'b0);
         join
         a.stalled = 1'b1;
         op(a, 1'b1, 1'b0);
         bus(fpbc_pkg::OFF_EXC_CTRL, 1'b0, 32'h0);
         chk("ctrl", q & 32'h9000_0700,
            {8'h80, 13'h0, rems[i] - 3'h1, 8'h0});
         op(mk(2'h3, 6'h08, 5'h00), 1'b1, 1'b0);
         op(mk(2'h3, 6'h18, 5'h00), 1'b0, 1'b0);
         a = mk(2'h0, 6'h00, 5'h00);
         a.reserved_op = 1'b1;
         op(a, 1'b1, 1'b0);
         chk("pending", pend, 1'b1);
         bus(fpbc_pkg::OFF_EXC_CTRL, 1'b1, 32'h4000_0000);
      end
      $display("test vector exception done");
      // reset while an exception is pending
      fork
         det(1'b0, 3'h0, e);
         op(mk(2'h3, 6'h18, 5'h00), 1'b1, 1'b0);
      join
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("pending", pend, 1'b0);
      bus(fpbc_pkg::OFF_EXC_CTRL, 1'b0, 32'h0);
      chk("ctrl", q, fpbc_pkg::EXC_CTRL_RST);
      op(mk(2'h0, 6'h00, 5'h00), 1'b0, 1'b0);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule // tb
